// >>> verilog/spc_pkg.sv
// package: constants, register map and carriers for the snooze power sequencer
package spc_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_ADC_MODE = 4'h1;
    localparam logic [3:0] OFS_ADC_CMD = 4'h2;
    localparam logic [3:0] OFS_STATUS = 4'h3;
    localparam logic [3:0] OFS_RESULT_BASE = 4'h8;
    // control fields
    localparam int CTRL_SLEEP_BIT = 0;
    localparam int CTRL_STANDBY_BIT = 1;
    localparam int CTRL_SNOOZE_EN_BIT = 2;
    // mode fields
    localparam int MODE_HW_BIT = 0;
    localparam int MODE_WAIT_BIT = 1;
    localparam int MODE_SCAN_BIT = 2;
    localparam int MODE_SEQ_BIT = 3;
    localparam int MODE_WAKE_SEL_BIT = 4;
    localparam int MODE_CH_LSB = 8;
    // command fields
    localparam int CMD_START_BIT = 0;
    localparam int CMD_POWER_BIT = 1;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [2:0] CHAN_RESET = 3'h0;
    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int STAB_NS = 1000;
    localparam int STAB_CYC = (STAB_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CONV_CYC = 12;
    localparam int RES_W = 12;
    localparam int SCAN_N = 4;

    typedef enum logic [1:0] {
        SPC_NORMAL,
        SPC_SLEEP,
        SPC_STANDBY,
        SPC_SNOOZE
    } spc_mode_t;

    typedef enum logic [1:0] {
        SPC_ADC_OFF,
        SPC_ADC_STAB,
        SPC_ADC_CONV
    } spc_adc_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } spc_bus_t;

    typedef struct packed {
        logic cpu_run;
        logic osc_run;
        logic periph_run;
        logic snooze_periph_run;
        logic retain;
    } spc_power_t;
endpackage : spc_pkg

// >>> verilog/spc_sequencer.sv
// module: low power mode sequencer with twelve bit converter control
`timescale 1ns/1ps
module spc_sequencer #(
    parameter int STAB = spc_pkg::STAB_CYC,
    parameter int CONV = spc_pkg::CONV_CYC
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire spc_pkg::spc_bus_t bus,
    output logic [15:0] rdata,
    input wire logic any_irq,
    input wire logic snooze_req,
    input wire logic external_pin_irq_zero,
    input wire logic rtc_alarm_or_period_event,
    input wire logic hw_trigger,
    input wire logic [spc_pkg::RES_W-1:0] sample_in,
    output logic [2:0] sample_chan,
    output spc_pkg::spc_power_t power,
    output spc_pkg::spc_mode_t lp_mode,
    output logic high_speed_internal_osc,
    output logic converter_power_enable,
    output logic scan_end
);
    typedef struct packed {
        spc_pkg::spc_mode_t mode;
        logic snooze_prev;
        logic [1:0] p0_sync;
        logic [1:0] p0_meta;
        logic [1:0] hw_meta;
        logic hw_prev;
        logic [1:0] rtc_ch;
        logic [7:0] adc_mode;
        logic [2:0] chan_sel;
        logic pwr;
        logic start_bit;
        spc_pkg::spc_adc_t adc;
        logic [15:0] cnt;
        logic [1:0] idx;
        logic done;
        logic [15:0] rdata;
        logic [3:0][spc_pkg::RES_W-1:0] res;
    } st_t;

    st_t s_reg;
    st_t s_next;
    logic p0_s;
    logic rtc_s;
    logic hw_s;
    logic wake;
    logic snooze_fall;
    logic [2:0] cur_ch;

    assign p0_s = s_reg.p0_sync[1];
    assign rtc_s = s_reg.rtc_ch[1];
    assign hw_s = s_reg.hw_meta[1];
    assign wake = p0_s | rtc_s;
    assign snooze_fall = s_reg.snooze_prev & ~snooze_req;
    // scan base above four wraps modulo eight; software keeps the base low
    assign cur_ch = s_reg.adc_mode[spc_pkg::MODE_SCAN_BIT] ? 3'(s_reg.chan_sel + {1'b0, s_reg.idx}) : s_reg.chan_sel;

    always_comb begin
        s_next = s_reg;
        s_next.p0_meta = {s_reg.p0_meta[0], external_pin_irq_zero};
        s_next.p0_sync = {s_reg.p0_sync[0], s_reg.p0_meta[1]};
        s_next.rtc_ch = {s_reg.rtc_ch[0], rtc_alarm_or_period_event};
        s_next.hw_meta = {s_reg.hw_meta[0], hw_trigger};
        s_next.hw_prev = hw_s;
        s_next.snooze_prev = snooze_req;
        s_next.done = 1'b0;
        s_next.rdata = 16'h0000;
        // register port
        if (bus.wr) begin
            case (bus.addr)
                spc_pkg::OFS_CTRL: begin
                    if (s_reg.mode == spc_pkg::SPC_NORMAL) begin
                        if (bus.wdata[spc_pkg::CTRL_STANDBY_BIT]) begin
                            s_next.mode = spc_pkg::SPC_STANDBY;
                        end else if (bus.wdata[spc_pkg::CTRL_SLEEP_BIT]) begin
                            s_next.mode = spc_pkg::SPC_SLEEP;
                        end
                    end
                end
                spc_pkg::OFS_ADC_MODE: begin
                    s_next.adc_mode = bus.wdata[7:0];
                    s_next.chan_sel = bus.wdata[spc_pkg::MODE_CH_LSB +: 3];
                end
                spc_pkg::OFS_ADC_CMD: begin
                    s_next.pwr = bus.wdata[spc_pkg::CMD_POWER_BIT];
                    s_next.start_bit = bus.wdata[spc_pkg::CMD_START_BIT];
                    if (!bus.wdata[spc_pkg::CMD_START_BIT]) begin
                        s_next.adc = spc_pkg::SPC_ADC_OFF;
                    end
                end
                default: begin
                end
            endcase
        end
        if (bus.rd) begin
            case (bus.addr)
                spc_pkg::OFS_ADC_MODE: s_next.rdata = {5'h00, s_reg.chan_sel, s_reg.adc_mode};
                spc_pkg::OFS_ADC_CMD: s_next.rdata = {14'h0000, s_reg.pwr, s_reg.start_bit};
                spc_pkg::OFS_STATUS: s_next.rdata = {12'h000, s_reg.adc, s_reg.mode};
                default: begin
                    if (bus.addr[3]) begin
                        s_next.rdata = {4'h0, s_reg.res[bus.addr[1:0]]};
                    end
                end
            endcase
        end
        // power mode sequencing
        case (s_reg.mode)
            spc_pkg::SPC_SLEEP: if (any_irq | wake) s_next.mode = spc_pkg::SPC_NORMAL;
            spc_pkg::SPC_STANDBY: begin
                if (wake) begin
                    s_next.mode = spc_pkg::SPC_NORMAL;
                end else if (snooze_req && !s_reg.snooze_prev) begin
                    s_next.mode = spc_pkg::SPC_SNOOZE;
                end
            end
            spc_pkg::SPC_SNOOZE: begin
                if (wake) begin
                    s_next.mode = spc_pkg::SPC_NORMAL;
                end else if (snooze_fall) begin
                    s_next.mode = spc_pkg::SPC_STANDBY;
                end
            end
            default: begin
            end
        endcase
        // converter sequencing; frozen in standby since its clock is gone
        if (s_reg.mode != spc_pkg::SPC_STANDBY) begin
            case (s_reg.adc)
                spc_pkg::SPC_ADC_OFF: begin
                    if (!s_reg.adc_mode[spc_pkg::MODE_HW_BIT]) begin
                        if (s_reg.start_bit && !s_reg.adc_mode[spc_pkg::MODE_WAIT_BIT] && s_reg.pwr) begin
                            s_next.adc = spc_pkg::SPC_ADC_CONV;
                            s_next.cnt = 16'h0000;
                            s_next.idx = 2'h0;
                        end else if (s_reg.start_bit && s_reg.adc_mode[spc_pkg::MODE_WAIT_BIT]) begin
                            s_next.adc = spc_pkg::SPC_ADC_STAB;
                            s_next.cnt = 16'h0000;
                        end
                    end else if (hw_s && !s_reg.hw_prev) begin
                        s_next.cnt = 16'h0000;
                        s_next.idx = 2'h0;
                        if (s_reg.adc_mode[spc_pkg::MODE_WAIT_BIT]) begin
                            s_next.adc = spc_pkg::SPC_ADC_STAB;
                        end else if (s_reg.pwr) begin
                            s_next.adc = spc_pkg::SPC_ADC_CONV;
                        end
                    end
                end
                spc_pkg::SPC_ADC_STAB: begin
                    s_next.cnt = s_reg.cnt + 16'h0001;
                    if (s_reg.cnt == 16'(STAB - 1)) begin
                        s_next.adc = spc_pkg::SPC_ADC_CONV;
                        s_next.cnt = 16'h0000;
                        s_next.idx = 2'h0;
                    end
                end
                spc_pkg::SPC_ADC_CONV: begin
                    s_next.cnt = s_reg.cnt + 16'h0001;
                    if (s_reg.cnt == 16'(CONV - 1)) begin
                        s_next.cnt = 16'h0000;
                        s_next.res[s_reg.adc_mode[spc_pkg::MODE_SCAN_BIT] ? s_reg.idx : 2'h0] = sample_in;
                        if (!s_reg.adc_mode[spc_pkg::MODE_SCAN_BIT] || s_reg.idx == 2'(spc_pkg::SCAN_N - 1)) begin
                            s_next.done = 1'b1;
                            s_next.idx = 2'h0;
                            if (!s_reg.adc_mode[spc_pkg::MODE_SEQ_BIT]) begin
                                s_next.adc = spc_pkg::SPC_ADC_OFF;
                                // a start written in this very cycle wins over the automatic clear
                                if (!(bus.wr && bus.addr == spc_pkg::OFS_ADC_CMD)) begin
                                    s_next.start_bit = 1'b0;
                                end
                            end
                        end else begin
                            s_next.idx = s_reg.idx + 2'h1;
                        end
                    end
                end
                default: s_next.adc = spc_pkg::SPC_ADC_OFF;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // standby gates the oscillator and peripheral clocks; retain stays high in every mode
    always_comb begin
        power.cpu_run = (s_reg.mode == spc_pkg::SPC_NORMAL);
        power.osc_run = (s_reg.mode != spc_pkg::SPC_STANDBY);
        power.periph_run = (s_reg.mode == spc_pkg::SPC_NORMAL) || (s_reg.mode == spc_pkg::SPC_SLEEP);
        power.snooze_periph_run = (s_reg.mode == spc_pkg::SPC_SNOOZE);
        power.retain = 1'b1;
    end

    assign lp_mode = s_reg.mode;
    assign rdata = s_reg.rdata;
    assign scan_end = s_reg.done;
    assign sample_chan = cur_ch;
    assign converter_power_enable = s_reg.pwr || (s_reg.adc != spc_pkg::SPC_ADC_OFF);
    assign high_speed_internal_osc = power.osc_run || (s_reg.mode == spc_pkg::SPC_SNOOZE);

    AST_SNOOZE_ENTRY: assert property (@(posedge ref_clk) disable iff (reset)
        (s_reg.mode == spc_pkg::SPC_STANDBY && snooze_req && !s_reg.snooze_prev && !wake)
        |=> s_reg.mode == spc_pkg::SPC_SNOOZE) else $error("snooze not entered");
    AST_SNOOZE_EXIT: assert property (@(posedge ref_clk) disable iff (reset)
        (s_reg.mode == spc_pkg::SPC_SNOOZE && snooze_fall && !wake)
        |=> s_reg.mode == spc_pkg::SPC_STANDBY) else $error("snooze not left");
    AST_WAKE: assert property (@(posedge ref_clk) disable iff (reset)
        (s_reg.mode inside {spc_pkg::SPC_SNOOZE, spc_pkg::SPC_STANDBY} && wake)
        |=> s_reg.mode == spc_pkg::SPC_NORMAL) else $error("wake missed");
    AST_CPU_HALT: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.mode != spc_pkg::SPC_NORMAL |-> !power.cpu_run) else $error("cpu runs in low power");
    AST_OSC_STOP: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.mode == spc_pkg::SPC_STANDBY |-> !power.osc_run && !power.periph_run) else $error("standby leak");
    AST_SLEEP_WAKE: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.mode == spc_pkg::SPC_SLEEP && any_irq |=> s_reg.mode == spc_pkg::SPC_NORMAL) else $error("sleep stuck");
    AST_ONESHOT_END: assert property (@(posedge ref_clk) disable iff (reset)
        scan_end && !s_reg.adc_mode[spc_pkg::MODE_SEQ_BIT] |-> s_reg.adc == spc_pkg::SPC_ADC_OFF) else $error("oneshot ran on");
    AST_SEQ_RUN: assert property (@(posedge ref_clk) disable iff (reset)
        scan_end && s_reg.adc_mode[spc_pkg::MODE_SEQ_BIT] && !$past(bus.wr) |-> s_reg.adc == spc_pkg::SPC_ADC_CONV) else $error("seq stopped");
    AST_SCAN_ORDER: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.adc == spc_pkg::SPC_ADC_CONV && $past(s_reg.adc) == spc_pkg::SPC_ADC_STAB |-> s_reg.idx == 2'h0) else $error("scan not from lowest");

    // converter start and conversion steps; a bus write in the same cycle may rewrite the mode, so the two start steps leave it out
    sequence seq_hw_edge;
        s_reg.mode != spc_pkg::SPC_STANDBY && s_reg.adc == spc_pkg::SPC_ADC_OFF && s_reg.adc_mode[spc_pkg::MODE_HW_BIT] && hw_s && !s_reg.hw_prev && !bus.wr;
    endsequence
    sequence seq_sw_start;
        s_reg.mode != spc_pkg::SPC_STANDBY && s_reg.adc == spc_pkg::SPC_ADC_OFF && !s_reg.adc_mode[spc_pkg::MODE_HW_BIT] && s_reg.start_bit && !bus.wr;
    endsequence
    sequence seq_scan_step;
        s_reg.mode != spc_pkg::SPC_STANDBY && s_reg.adc == spc_pkg::SPC_ADC_CONV && s_reg.cnt == 16'(CONV - 1) && s_reg.adc_mode[spc_pkg::MODE_SCAN_BIT] && s_reg.idx != 2'h3;
    endsequence
    sequence seq_conv_final;
        s_reg.mode != spc_pkg::SPC_STANDBY && s_reg.adc == spc_pkg::SPC_ADC_CONV && s_reg.cnt == 16'(CONV - 1) && (!s_reg.adc_mode[spc_pkg::MODE_SCAN_BIT] || s_reg.idx == 2'h3);
    endsequence

    AST_HW_NOWAIT: assert property (@(posedge ref_clk) disable iff (reset)
        seq_hw_edge
        |=> (s_reg.adc == spc_pkg::SPC_ADC_CONV || !$past(s_reg.pwr) || $past(s_reg.adc_mode[spc_pkg::MODE_WAIT_BIT])))
        else $error("hardware trigger did not start conversion");
    AST_HW_WAIT: assert property (@(posedge ref_clk) disable iff (reset)
        seq_hw_edge
        |=> (s_reg.adc == spc_pkg::SPC_ADC_STAB || !$past(s_reg.adc_mode[spc_pkg::MODE_WAIT_BIT])))
        else $error("hardware trigger did not power up");
    AST_SW_NOWAIT: assert property (@(posedge ref_clk) disable iff (reset)
        seq_sw_start
        |=> (s_reg.adc == spc_pkg::SPC_ADC_CONV || !$past(s_reg.pwr) || $past(s_reg.adc_mode[spc_pkg::MODE_WAIT_BIT])))
        else $error("software start ignored");
    AST_SW_WAIT: assert property (@(posedge ref_clk) disable iff (reset)
        seq_sw_start
        |=> (s_reg.adc == spc_pkg::SPC_ADC_STAB || !$past(s_reg.adc_mode[spc_pkg::MODE_WAIT_BIT])))
        else $error("software start did not power up");
    AST_SW_NOPWR: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.adc == spc_pkg::SPC_ADC_OFF && !s_reg.adc_mode[spc_pkg::MODE_HW_BIT] && !s_reg.adc_mode[spc_pkg::MODE_WAIT_BIT] && !s_reg.pwr && !bus.wr
        |=> s_reg.adc == spc_pkg::SPC_ADC_OFF)
        else $error("no-wait start without power");
    AST_HW_IGNORES_START: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.adc == spc_pkg::SPC_ADC_OFF && s_reg.adc_mode[spc_pkg::MODE_HW_BIT] && !(hw_s && !s_reg.hw_prev) && !bus.wr
        |=> s_reg.adc == spc_pkg::SPC_ADC_OFF)
        else $error("hardware mode started without trigger");

    // timing of the stabilisation wait and of each conversion
    AST_STAB_LIMIT: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.adc == spc_pkg::SPC_ADC_STAB
        |-> s_reg.cnt < 16'(STAB))
        else $error("stabilisation wait overran");
    AST_STAB_DONE: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.mode != spc_pkg::SPC_STANDBY && s_reg.adc == spc_pkg::SPC_ADC_STAB && s_reg.cnt == 16'(STAB - 1) && !bus.wr
        |=> s_reg.adc == spc_pkg::SPC_ADC_CONV && s_reg.idx == 2'h0)
        else $error("conversion did not follow the wait");
    AST_CONV_LIMIT: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.adc == spc_pkg::SPC_ADC_CONV
        |-> s_reg.cnt < 16'(CONV))
        else $error("conversion overran");
    AST_SCAN_STEP: assert property (@(posedge ref_clk) disable iff (reset)
        seq_scan_step
        |=> s_reg.idx == $past(s_reg.idx) + 2'h1)
        else $error("scan skipped a channel");
    AST_CONV_FINAL: assert property (@(posedge ref_clk) disable iff (reset)
        seq_conv_final
        |=> scan_end)
        else $error("scan end missing");
    AST_DONE_SRC: assert property (@(posedge ref_clk) disable iff (reset)
        scan_end
        |-> $past(s_reg.adc) == spc_pkg::SPC_ADC_CONV)
        else $error("scan end without conversion");
    AST_DONE_PULSE: assert property (@(posedge ref_clk) disable iff (reset)
        scan_end && CONV > 1
        |=> !scan_end)
        else $error("scan end longer than one cycle");
    AST_ONESHOT_CLEAR: assert property (@(posedge ref_clk) disable iff (reset)
        scan_end && !s_reg.adc_mode[spc_pkg::MODE_SEQ_BIT] && !$past(bus.wr)
        |-> !s_reg.start_bit)
        else $error("start bit left set");
    AST_SELECT_CHAN: assert property (@(posedge ref_clk) disable iff (reset)
        !s_reg.adc_mode[spc_pkg::MODE_SCAN_BIT]
        |-> sample_chan == s_reg.chan_sel)
        else $error("select mode moved channel");
    AST_PWR_EN: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.adc != spc_pkg::SPC_ADC_OFF
        |-> converter_power_enable)
        else $error("converter unpowered while busy");
    AST_RESULT_WIDTH: assert property (@(posedge ref_clk) disable iff (reset)
        1'b1
        |-> rdata[15:12] == 4'h0)
        else $error("read data wider than a result");

    // power mode holding and clock gating
    AST_STANDBY_FREEZE: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.mode == spc_pkg::SPC_STANDBY && !bus.wr
        |=> $stable(s_reg.adc) && $stable(s_reg.cnt))
        else $error("converter moved in standby");
    AST_STANDBY_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.mode == spc_pkg::SPC_STANDBY && !wake && !(snooze_req && !s_reg.snooze_prev)
        |=> s_reg.mode == spc_pkg::SPC_STANDBY)
        else $error("standby left without request");
    AST_SNOOZE_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.mode == spc_pkg::SPC_SNOOZE && !wake && !snooze_fall
        |=> s_reg.mode == spc_pkg::SPC_SNOOZE)
        else $error("snooze left early");
    AST_NO_SLEEP_ENTRY: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.mode inside {spc_pkg::SPC_STANDBY, spc_pkg::SPC_SNOOZE}
        |=> s_reg.mode != spc_pkg::SPC_SLEEP)
        else $error("sleep entered from standby");
    AST_SLEEP_WAKE_PIN: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.mode == spc_pkg::SPC_SLEEP && wake
        |=> s_reg.mode == spc_pkg::SPC_NORMAL)
        else $error("pin event missed in sleep");
    AST_SLEEP_PERIPH: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.mode == spc_pkg::SPC_SLEEP
        |-> power.periph_run && !power.cpu_run)
        else $error("sleep gating wrong");
    AST_OSC_SNOOZE: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.mode == spc_pkg::SPC_SNOOZE
        |-> high_speed_internal_osc)
        else $error("oscillator off in snooze");
    AST_OSC_STANDBY: assert property (@(posedge ref_clk) disable iff (reset)
        s_reg.mode == spc_pkg::SPC_STANDBY
        |-> !high_speed_internal_osc)
        else $error("oscillator on in standby");
    AST_RETAIN: assert property (@(posedge ref_clk) disable iff (reset)
        1'b1
        |-> power.retain)
        else $error("retention dropped");
endmodule : spc_sequencer

// >>> test/spc_xfer_model.sv
// partner model: transfer controller side of the snooze request
`timescale 1ns/1ps
module spc_xfer_model #(
    parameter int DUMMY = 3
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic act,
    input wire logic scan_end,
    output logic snooze_req
);
    int pad;
    logic done;
    // dummy transfers pad the tail so the request drops DUMMY+1 cycles after the last scan end it sees; a scan end during the padding restarts the count
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            snooze_req <= 1'b0;
            done <= 1'b0;
            pad <= 0;
        end else if (act) begin
            snooze_req <= 1'b1;
            done <= 1'b0;
        end else if (scan_end && snooze_req) begin
            done <= 1'b1;
            pad <= DUMMY;
        end else if (done && pad > 0) begin
            pad <= pad - 1;
        end else if (done) begin
            snooze_req <= 1'b0;
            done <= 1'b0;
        end
    end
endmodule : spc_xfer_model

// >>> test/snooze_power_mode_adc_ctrl_test.sv
// testbench: power mode sequencing and converter control
`timescale 1ns/1ps
module snooze_power_mode_adc_ctrl_test;
    localparam int STAB = 2;
    localparam int CONV = 2;
    logic ref_clk, reset, any_irq, ext_irq, rtc_evt, hw_trigger, act, snooze_req, scan_end, hsosc, pwr_en, rd_d;
    spc_pkg::spc_bus_t bus;
    spc_pkg::spc_power_t power;
    spc_pkg::spc_mode_t lp_mode;
    logic [15:0] rdata;
    logic [11:0] sample_in;
    logic [11:0] tbl [8];
    logic [2:0] sample_chan;
    logic [15:0] exp_q [$];
    logic [15:0] tm [4] = '{16'h0300, 16'h0602, 16'h0501, 16'h0403};
    int errors, checked, seed, n;
    // converter input follows the channel so each result names its source
    assign sample_in = tbl[sample_chan];
    spc_sequencer #(.STAB(STAB), .CONV(CONV)) i_dut (.ref_clk(ref_clk), .reset(reset), .bus(bus),
        .rdata(rdata), .any_irq(any_irq), .snooze_req(snooze_req), .external_pin_irq_zero(ext_irq),
        .rtc_alarm_or_period_event(rtc_evt), .hw_trigger(hw_trigger), .sample_in(sample_in),
        .sample_chan(sample_chan), .power(power), .lp_mode(lp_mode), .high_speed_internal_osc(hsosc),
        .converter_power_enable(pwr_en), .scan_end(scan_end));
    spc_xfer_model i_xfer (.ref_clk(ref_clk), .reset(reset), .act(act), .scan_end(scan_end), .snooze_req(snooze_req));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic results;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    // a gap cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        bus <= '{a, 16'h0000, 1'b0, 1'b1};
        exp_q.push_back(e);
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        @(posedge ref_clk);
    endtask : rd
    // sel: 0 any_irq, 1 act, 2 ext_irq, 3 hw_trigger, else rtc_evt
    task automatic pulse(input int sel, input int len);
        case (sel)
            0: any_irq <= 1'b1;
            1: act <= 1'b1;
            2: ext_irq <= 1'b1;
            3: hw_trigger <= 1'b1;
            default: rtc_evt <= 1'b1;
        endcase
        repeat (len) @(posedge ref_clk);
        {any_irq, ext_irq, rtc_evt, hw_trigger, act} <= 5'h00;
    endtask : pulse
    task automatic wait_mode(input spc_pkg::spc_mode_t m);
        n = 0;
        while (lp_mode !== m && n < 8) begin
            @(negedge ref_clk);
            n++;
        end
        check(16'(lp_mode), 16'(m));
        @(posedge ref_clk);
    endtask : wait_mode
    task automatic wait_end(input int lim);
        n = 0;
        while (scan_end !== 1'b1 && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
    endtask : wait_end
    always @(posedge ref_clk) rd_d <= bus.rd;
    always @(negedge ref_clk) begin
        if (rd_d && exp_q.size() > 0) check(rdata, exp_q.pop_front());
    end
    initial begin
        #(100 * 20000);
        errors++;
        results();
    end
    initial begin
        seed = 32'h6874;
        bus = '0;
        {any_irq, ext_irq, rtc_evt, hw_trigger, act} = 5'h00;
        for (int i = 0; i < 8; i++) tbl[i] = 12'($random(seed));
        reset = 1'b1;
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        check(16'(power), 16'h001D);
        wr(spc_pkg::OFS_CTRL, 16'h0001);
        wait_mode(spc_pkg::SPC_SLEEP);
        check(16'({power.cpu_run, power.periph_run}), 16'h0001);
        pulse(0, 1);
        wait_mode(spc_pkg::SPC_NORMAL);
        rd(4'h5, 16'h0000);
        wr(spc_pkg::OFS_CTRL, 16'h0002);
        wait_mode(spc_pkg::SPC_STANDBY);
        check(16'({hsosc, power.osc_run, power.retain}), 16'h0001);
        wr(spc_pkg::OFS_CTRL, 16'h0001);
        wait_mode(spc_pkg::SPC_STANDBY);
        pulse(1, 1);
        wait_mode(spc_pkg::SPC_SNOOZE);
        check(16'({power.cpu_run, power.snooze_periph_run, hsosc}), 16'h0003);
        wr(spc_pkg::OFS_ADC_MODE, 16'h0206);
        wr(spc_pkg::OFS_ADC_CMD, 16'h0001);
        wait_end(40);
        check(16'(n >= STAB + 4 * CONV - 2 && n <= STAB + 4 * CONV + 2), 16'h0001);
        check(16'(lp_mode), 16'(spc_pkg::SPC_SNOOZE));
        check(16'(pwr_en), 16'h0000);
        wait_mode(spc_pkg::SPC_STANDBY);
        pulse(2, 2);
        wait_mode(spc_pkg::SPC_NORMAL);
        for (int i = 0; i < 4; i++) rd(4'(8 + i), 16'(tbl[2 + i]));
        for (int i = 0; i < 4; i++) begin
            wr(spc_pkg::OFS_ADC_MODE, tm[i]);
            if (!tm[i][1]) wr(spc_pkg::OFS_ADC_CMD, 16'h0002);
            if (!tm[i][1]) check(16'(pwr_en), 16'h0001);
            if (tm[i][0]) pulse(3, 2);
            else wr(spc_pkg::OFS_ADC_CMD, tm[i][1] ? 16'h0001 : 16'h0003);
            wait_end(40);
            check(16'(n < 40), 16'h0001);
            rd(4'h8, 16'(tbl[tm[i][10:8]]));
            wr(spc_pkg::OFS_ADC_CMD, 16'h0000);
        end
        wr(spc_pkg::OFS_ADC_MODE, 16'h010A);
        wr(spc_pkg::OFS_ADC_CMD, 16'h0001);
        wait_end(40);
        wait_end(40);
        check(16'(n < 40), 16'h0001);
        wr(spc_pkg::OFS_ADC_CMD, 16'h0000);
        wait_end(30);
        check(16'(n), 16'h001E);
        wr(spc_pkg::OFS_CTRL, 16'h0002);
        wait_mode(spc_pkg::SPC_STANDBY);
        pulse(1, 1);
        wait_mode(spc_pkg::SPC_SNOOZE);
        pulse(4, 2);
        wait_mode(spc_pkg::SPC_NORMAL);
        repeat (3) @(posedge ref_clk);
        results();
    end
endmodule : snooze_power_mode_adc_ctrl_test
